// ===== design/bit_fifo.sv
// Small valid/ready FIFO for the serial data stream
`timescale 1ns/1ps
module bit_fifo #(
   parameter int WIDTH = 1,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // Drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW:0] wp;
      logic [AW:0] rp;
   } fifo_state_s;
   fifo_state_s q, d;
   logic full, empty, push, pop;

   assign full = (q.wp[AW-1:0] == q.rp[AW-1:0]) && (q.wp[AW] != q.rp[AW]);
   assign empty = (q.wp == q.rp);
   assign push = in_valid_i && !full;
   assign pop = out_ready_i && !empty;
   assign in_ready_o = !full;
   assign out_valid_o = !empty;
   assign out_data_o = q.mem[q.rp[AW-1:0]];

   always_comb begin
      d = q;
      if (push) begin
         d.mem[q.wp[AW-1:0]] = in_data_i;
         d.wp = q.wp + 1'b1;
      end
      if (pop) begin
         d.rp = q.rp + 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
endmodule

// ===== design/dual_stage_compare_timer.sv
// Dual stage 4/8/12-bit compare timer with output modulator
`timescale 1ns/1ps
module dual_stage_compare_timer
   import timer2_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Configuration
   input wire timer2_pkg::timer_cfg_s cfg_i,
   input wire logic port_alt_select_i,
   // Power state
   input wire logic sleep_i,
   input wire logic osc_keep_running_i,
   // Clock sources
   input wire logic ext_count_clock_in_i,
   input wire logic timer1_tick_i,
   input wire logic shift_clock_i,
   // Serial unit data
   input wire logic shift_halt_flag_i,
   input wire logic ser_bit_valid_i,
   input wire logic ser_bit_i,
   output logic ser_bit_ready_o,
   // Results
   output logic timer_wave_out_o,
   output logic prescale_clock_out_o,
   output logic timer_irq_o,
   output timer2_pkg::timer_status_s status_o
);
   import timer2_pkg::*;

   typedef struct packed {
      logic [SYNC_STAGES-1:0] ext_sync;
      logic ext_level;
      logic [LOW_W-1:0] low;
      logic [HIGH_W-1:0] high;
      logic out_ff;
      logic pwm_lock;
      logic run_prev;
      logic halt_prev;
      logic mod_on;
      logic cur_bit;
      logic half;
      logic biphase;
      logic wave;
      logic prescale_clock_out;
      logic irq;
      logic ready;
   } timer_state_s;

   timer_state_s q, d;

   logic mode1, split, use_ext, osc_gate;
   logic src_tick, ext_rise, low_run, low_tick;
   logic low_hit, low_stage_overflow, cm1;
   logic shaper_in, shaper_tick, shaper_level, shaper_clear;
   logic high_tick, match12, match8, match, ovf2;
   logic launch, tog_match, tog_ovf, irq_ev;
   logic fifo_valid, fifo_bit, bit_take, mod_start, mod_stop;
   logic ser_ready;
   logic mode2, mode3, mode4, wave_next, irq_match, irq_ovf;

   // Mode decode, one line per mode code
   assign mode1 = (cfg_i.mode_sel == MODE_CASCADE);
   assign mode2 = (cfg_i.mode_sel == MODE_PRESCALED);
   assign mode3 = (cfg_i.mode_sel == MODE_SPLIT_RUN);
   assign mode4 = (cfg_i.mode_sel == MODE_SPLIT_STOP);
   assign split = mode3 || mode4;

   // External input only in split modes
   assign use_ext = split && port_alt_select_i;

   assign osc_gate = !(sleep_i && !osc_keep_running_i);

   always_comb begin
      unique case (cfg_i.clk_sel)
         CLK_SYSTEM: src_tick = osc_gate;
         CLK_TIMER1: src_tick = osc_gate && timer1_tick_i;
         CLK_SHIFT: src_tick = osc_gate && shift_clock_i;
         default: src_tick = 1'b0;
      endcase
   end

   // Pin limited to a quarter of the clock rate, the price of one clock domain
   // Pin edge taken once stages agree
   assign ext_rise = (q.ext_sync[1] == q.ext_sync[2]) && q.ext_sync[2] && !q.ext_level;

   // Low stage halted in mode 4
   assign low_run = cfg_i.run_control && !mode4;
   assign low_tick = low_run && src_tick;
   assign low_hit = (q.low == cfg_i.low_compare);

   assign low_stage_overflow = mode1 && low_tick && (q.low == LOW_TOP);

   assign cm1 = !mode1 && low_tick && low_hit;

   // Shaper forms carrier from low stage in mode 2, from the raw clock or pin in split modes
   always_comb begin
      if (mode2) begin
         shaper_in = cm1;
      end else if (split) begin
         shaper_in = use_ext ? ext_rise : src_tick;
      end else begin
         shaper_in = 1'b0;
      end
   end

   // Shaper restarts its divide cycle on every launch
   // Stop clears the shaper too
   assign shaper_clear = !cfg_i.run_control;

   duty_shaper u_shaper (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .clear_i(shaper_clear),
      .duty_sel_i(cfg_i.duty_sel),
      .tick_i(shaper_in && cfg_i.run_control),
      .tick_o(shaper_tick),
      .level_o(shaper_level)
   );

   assign high_tick = mode1 ? low_stage_overflow : shaper_tick;

   assign match12 = mode1 && low_tick && low_hit && (q.high == cfg_i.high_compare);

   // Match at value v ends v+1 counts
   assign match8 = !mode1 && high_tick && (q.high == cfg_i.high_compare);
   assign match = match12 || match8;

   // Overflow only if not reset by match
   assign ovf2 = high_tick && (q.high == HIGH_TOP)
      && !(match && cfg_i.compare_action_mask.match_reset);

   // Start edge found from the registered run bit
   // Toggle at timer start
   assign launch = cfg_i.run_control && !q.run_prev && cfg_i.toggle_on_launch;

   // Later matches ignored in pulse-width mode
   assign tog_match = match && cfg_i.compare_action_mask.match_toggle
      && !((cfg_i.out_mode == OUT_PWM) && q.pwm_lock);

   assign tog_ovf = ovf2 && cfg_i.compare_action_mask.ovf_toggle;

   assign irq_match = match && cfg_i.compare_action_mask.match_irq;
   assign irq_ovf = ovf2 && cfg_i.compare_action_mask.ovf_irq;
   assign irq_ev = irq_match || irq_ovf;

   assign mod_start = q.halt_prev && !shift_halt_flag_i;

   // Low match ends the bit stream in mode 3
   assign mod_stop = shift_halt_flag_i || (mode3 && cm1);

   // Serial bits wait here so the shifter may run ahead of the bit clock
   assign bit_take = q.mod_on && shift_clock_i && fifo_valid;

   // Output stage, one source per mode
   always_comb begin
      unique case (cfg_i.out_mode)
         // Carrier gated by the toggle flip-flop
         OUT_BURST_FF: begin
            wave_next = shaper_level && q.out_ff;
         end
         // Carrier gated by the serial data bit
         OUT_BURST_DATA: begin
            wave_next = shaper_level && q.cur_bit && q.mod_on;
         end
         // Level change at each bit start
         OUT_BIPHASE: begin
            wave_next = q.biphase && q.mod_on;
         end
         // Bit value inverted for the second half
         OUT_MANCHESTER: begin
            wave_next = (q.cur_bit ^ q.half) && q.mod_on;
         end
         // Serial data passed straight through
         OUT_SERIAL: begin
            wave_next = q.cur_bit && q.mod_on;
         end
         // Pulse width, duty set by the first match
         OUT_PWM: begin
            wave_next = q.out_ff;
         end
         // Toggle mode and spare codes show the flip-flop
         default: begin
            wave_next = q.out_ff;
         end
      endcase
   end

   // Eight deep so a whole shifter byte fits
   bit_fifo #(
      .WIDTH(FIFO_WIDTH),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .in_valid_i(ser_bit_valid_i),
      .in_ready_o(ser_ready),
      .in_data_i(ser_bit_i),
      .out_valid_o(fifo_valid),
      .out_ready_i(bit_take),
      .out_data_o(fifo_bit)
   );

   always_comb begin
      d = q;
      // Three stage synchroniser; first stage feeds only the second
      d.ext_sync = {q.ext_sync[SYNC_STAGES-2:0], ext_count_clock_in_i};
      if (q.ext_sync[1] == q.ext_sync[2]) begin
         d.ext_level = q.ext_sync[2];
      end
      d.run_prev = cfg_i.run_control;
      d.halt_prev = shift_halt_flag_i;
      d.ready = ser_ready;

      if (!cfg_i.run_control) begin
         d.low = LOW_RESET;
         d.high = HIGH_RESET;
         d.pwm_lock = 1'b0;
      end else begin
         // Mode 4 clears the prescaler only
         if (mode4) begin
            d.low = LOW_RESET;
         end else if (low_tick) begin
            if (mode1) begin
               if (match12 && cfg_i.compare_action_mask.match_reset) begin
                  d.low = LOW_RESET;
               end else begin
                  d.low = q.low + 1'b1;
               end
            end else if (low_hit) begin
               d.low = LOW_RESET;
            end else begin
               d.low = q.low + 1'b1;
            end
         end
         if (match && cfg_i.compare_action_mask.match_reset) begin
            d.high = HIGH_RESET;
         end else if (high_tick) begin
            d.high = q.high + 1'b1;
         end
         // Lock after first match, release on overflow
         if (ovf2) begin
            d.pwm_lock = 1'b0;
         end else if (match) begin
            d.pwm_lock = 1'b1;
         end
      end

      // Match, overflow and launch each invert the flip-flop; two at once cancel
      if (tog_match ^ tog_ovf ^ launch) begin
         d.out_ff = !q.out_ff;
      end

      if (mod_stop) begin
         d.mod_on = 1'b0;
      end else if (mod_start) begin
         d.mod_on = 1'b1;
      end

      if (bit_take) begin
         d.cur_bit = fifo_bit;
         d.half = 1'b0;
         d.biphase = !q.biphase;
      end else if (match && !q.half) begin
         d.half = 1'b1;
         if (!q.cur_bit) begin
            d.biphase = !q.biphase;
         end
      end
      if (!q.mod_on) begin
         d.half = 1'b0;
      end

      // Registered pin level
      // Pin driven from a flip-flop so no mux glitch reaches it
      d.wave = wave_next;

      // Prescale output source per mode
      // Pulses registered, one cycle after the event tick
      d.prescale_clock_out = mode1 ? low_stage_overflow : cm1;
      d.irq = irq_ev;
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign timer_wave_out_o = q.wave;
   assign prescale_clock_out_o = q.prescale_clock_out;
   assign timer_irq_o = q.irq;
   assign ser_bit_ready_o = q.ready;
   assign status_o = '{low_count: q.low, high_count: q.high,
                       modulator_on: q.mod_on, output_toggle_ff: q.out_ff};
endmodule

// ===== design/duty_shaper.sv
// Two-bit divider that doubles as duty cycle generator
`timescale 1ns/1ps
module duty_shaper
   import timer2_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Control
   input wire logic clear_i,
   input wire logic [DUTY_W-1:0] duty_sel_i,
   input wire logic tick_i,
   // Results
   output logic tick_o,
   output logic level_o
);
   typedef struct packed {
      logic [DUTY_W-1:0] cnt;
      logic level;
   } shaper_state_s;
   shaper_state_s q, d;
   logic [DUTY_W-1:0] last;
   logic wrap;

   // Bypass divides by one, quarter duty by four
   assign last = ~duty_sel_i;
   assign wrap = (q.cnt >= last);
   assign tick_o = tick_i && wrap;
   assign level_o = q.level;

   always_comb begin
      d = q;
      if (clear_i) begin
         d = '0;
      end else if (tick_i) begin
         d.cnt = wrap ? '0 : q.cnt + 1'b1;
         if (duty_sel_i == DUTY_BYPASS) begin
            d.level = !q.level;
         end else begin
            // High during the first input period only
            d.level = wrap;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
endmodule

// ===== design/timer2_pkg.sv
// Shared constants and configuration and status types of the dual stage compare timer
package timer2_pkg;
   localparam int LOW_W = 4;
   localparam int HIGH_W = 8;
   localparam int DUTY_W = 2;
   localparam int FIFO_DEPTH = 8;
   localparam int FIFO_WIDTH = 1;
   localparam int SYNC_STAGES = 3;
   localparam int CLK_PERIOD_NS = 25;
   // Mode select codes
   localparam logic [1:0] MODE_CASCADE = 2'h3;
   localparam logic [1:0] MODE_PRESCALED = 2'h2;
   localparam logic [1:0] MODE_SPLIT_RUN = 2'h1;
   localparam logic [1:0] MODE_SPLIT_STOP = 2'h0;
   // Clock source codes
   localparam logic [1:0] CLK_SYSTEM = 2'h0;
   localparam logic [1:0] CLK_TIMER1 = 2'h1;
   localparam logic [1:0] CLK_SHIFT = 2'h2;
   // Duty shaper codes
   localparam logic [1:0] DUTY_BYPASS = 2'h3;
   localparam logic [1:0] DUTY_HALF = 2'h2;
   localparam logic [1:0] DUTY_THIRD = 2'h1;
   localparam logic [1:0] DUTY_QUARTER = 2'h0;
   // Output mode codes
   localparam logic [2:0] OUT_TOGGLE = 3'h7;
   localparam logic [2:0] OUT_BURST_FF = 3'h6;
   localparam logic [2:0] OUT_BURST_DATA = 3'h5;
   localparam logic [2:0] OUT_BIPHASE = 3'h4;
   localparam logic [2:0] OUT_MANCHESTER = 3'h3;
   localparam logic [2:0] OUT_SERIAL = 3'h2;
   localparam logic [2:0] OUT_PWM = 3'h0;
   // Reset and top values
   localparam logic [LOW_W-1:0] LOW_RESET = 4'h0;
   localparam logic [HIGH_W-1:0] HIGH_RESET = 8'h00;
   localparam logic [HIGH_W-1:0] HIGH_TOP = 8'hff;
   localparam logic [LOW_W-1:0] LOW_TOP = 4'hf;

   typedef struct packed {
      logic match_reset;
      logic match_toggle;
      logic match_irq;
      logic ovf_toggle;
      logic ovf_irq;
   } action_mask_s;

   typedef struct packed {
      logic [1:0] clk_sel;
      logic toggle_on_launch;
      logic run_control;
      logic [DUTY_W-1:0] duty_sel;
      logic [1:0] mode_sel;
      logic [2:0] out_mode;
      logic [LOW_W-1:0] low_compare;
      logic [HIGH_W-1:0] high_compare;
      action_mask_s compare_action_mask;
   } timer_cfg_s;

   typedef struct packed {
      logic [LOW_W-1:0] low_count;
      logic [HIGH_W-1:0] high_count;
      logic modulator_on;
      logic output_toggle_ff;
   } timer_status_s;
endpackage

// ===== sim/dual_stage_compare_timer_asserts.sv
// Port assertions for the dual stage compare timer
`timescale 1ns/1ps
module timer_port_checker
   import timer2_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Watched ports
   input wire timer2_pkg::timer_cfg_s cfg_i,
   input wire logic sleep_i,
   input wire logic shift_halt_flag_i,
   input wire logic prescale_clock_out_o,
   input wire logic timer_irq_o,
   input wire timer2_pkg::timer_status_s status_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   logic run_prev_q;
   logic tick;
   logic hit;
   logic [11:0] cnt;
   // Launch edge left out, a start toggle may mix in there
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         run_prev_q <= 1'b0;
      end else begin
         run_prev_q <= cfg_i.run_control;
      end
   end
   assign cnt = {status_o.high_count, status_o.low_count};
   assign tick = run_prev_q && cfg_i.run_control && cfg_i.mode_sel == MODE_CASCADE
      && cfg_i.clk_sel == CLK_SYSTEM && !sleep_i;
   assign hit = tick && cnt == {cfg_i.high_compare, cfg_i.low_compare};
   run_clear_a: assert property (!cfg_i.run_control |=> cnt == 12'h000)
      else $error("counts not cleared while stopped");
   cascade_step_a: assert property (tick |=>
      cnt == $past(cnt) + 12'h001 || cnt == 12'h000) else $error("cascade count did not step");
   cascade_wrap_a: assert property (hit && cfg_i.compare_action_mask.match_reset |=>
      cnt == 12'h000) else $error("count not restarted on match");
   match_irq_a: assert property (hit && cfg_i.compare_action_mask.match_irq |=>
      timer_irq_o) else $error("no irq after match");
   match_toggle_a: assert property (hit && cfg_i.compare_action_mask.match_toggle
      && !cfg_i.compare_action_mask.ovf_toggle |=> $changed(status_o.output_toggle_ff))
      else $error("flip-flop not toggled on match");
   low_ovf_prescale_clock_out_a: assert property (tick && status_o.low_count == LOW_TOP
      && !cfg_i.compare_action_mask.match_reset |=> prescale_clock_out_o)
      else $error("no prescale pulse on low overflow");
   halt_stop_a: assert property (shift_halt_flag_i |=> !status_o.modulator_on)
      else $error("modulator running while halted");
   launch_toggle_a: assert property ($rose(cfg_i.run_control) && cfg_i.toggle_on_launch
      && cfg_i.compare_action_mask == '0 |=> $changed(status_o.output_toggle_ff))
      else $error("no toggle at start");
   cover property (hit);
   cover property ($fell(shift_halt_flag_i));
   cover property (prescale_clock_out_o);
endmodule
bind dual_stage_compare_timer timer_port_checker i_timer_port_checker (.clk_i, .rst_b_i,
   .cfg_i, .sleep_i, .shift_halt_flag_i, .prescale_clock_out_o, .timer_irq_o, .status_o);

// ===== sim/serial_unit_model.sv
// Behavioural serial shift unit feeding the timer bit stream
`timescale 1ns/1ps
module serial_unit_model (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Bench control and timer side
   input wire logic go_i,
   input wire logic ready_i,
   output logic halt_o = 1'b1,
   output logic shift_o = 1'b0,
   output logic valid_o = 1'b0,
   output logic bit_o = 1'b0
);
   localparam logic [7:0] FRAME = 8'hb5;
   int sent_q = 0;
   int div_q = 0;
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         halt_o <= 1'b1;
         shift_o <= 1'b0;
         valid_o <= 1'b0;
         sent_q <= 0;
         div_q <= 0;
      end else begin
         shift_o <= 1'b0;
         if (!go_i) begin
            halt_o <= 1'b1;
         end else if (sent_q < 8) begin
            if (!valid_o) begin
               valid_o <= 1'b1;
               bit_o <= FRAME[sent_q];
            end else if (ready_i) begin
               sent_q <= sent_q + 1;
               valid_o <= (sent_q < 7);
               // Released line shows the inverse, never a stale bit
               bit_o <= (sent_q < 7) ? FRAME[sent_q + 1] : ~bit_o;
            end
         // Shifter start, clock only in frame
         end else begin
            halt_o <= 1'b0;
            div_q <= (div_q == 3) ? 0 : div_q + 1;
            shift_o <= (div_q == 3) && !halt_o;
         end
      end
   end
endmodule

// ===== sim/test_dual_stage_compare_timer.sv
// Self-checking bench for the dual stage compare timer
`timescale 1ns/1ps
module test_dual_stage_compare_timer;
   import timer2_pkg::*;
   typedef struct {
      logic [1:0] mode;
      logic [1:0] src;
      logic [1:0] duty;
      logic [4:0] mask;
      logic [3:0] lo;
      logic [7:0] hi;
      int gap;
   } row_s;
   // Gap is irq spacing in clocks: (v+1) times any prescale
   row_s rows [10] = '{
      '{MODE_CASCADE, CLK_SYSTEM, DUTY_BYPASS, 5'h1c, 4'h0, 8'h00, 1},
      '{MODE_CASCADE, CLK_SYSTEM, DUTY_BYPASS, 5'h1c, 4'h5, 8'h01, 22},
      '{MODE_CASCADE, CLK_SYSTEM, DUTY_BYPASS, 5'h0c, 4'hf, 8'hff, 4096},
      '{MODE_CASCADE, CLK_TIMER1, DUTY_BYPASS, 5'h1c, 4'h3, 8'h00, 12},
      '{MODE_PRESCALED, CLK_SYSTEM, DUTY_BYPASS, 5'h1c, 4'h1, 8'h02, 6},
      '{MODE_PRESCALED, CLK_SYSTEM, DUTY_HALF, 5'h1c, 4'h1, 8'h02, 12},
      '{MODE_PRESCALED, CLK_SYSTEM, DUTY_THIRD, 5'h1c, 4'h1, 8'h02, 18},
      '{MODE_PRESCALED, CLK_SYSTEM, DUTY_QUARTER, 5'h1c, 4'h1, 8'h02, 24},
      '{MODE_SPLIT_RUN, CLK_SYSTEM, DUTY_BYPASS, 5'h1c, 4'h2, 8'h09, 10},
      '{MODE_SPLIT_STOP, CLK_SYSTEM, DUTY_BYPASS, 5'h1c, 4'h2, 8'h09, 10}};
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   timer_cfg_s cfg = '0;
   logic alt = 1'b0, sleep = 1'b0, osc = 1'b0, ext = 1'b0, t1 = 1'b0, go = 1'b0;
   logic halt, shift, sv, sb, ready, wave, prescale_clock_out, irq;
   timer_status_s st;
   logic [1:0] t1_div = 2'h0;
   int n_mismatch = 0;
   int checks = 0;
   int k;
   always #12.5 clk_i = ~clk_i;
   // Other interval timer ticks every third clock
   always @(posedge clk_i) begin
      t1_div <= (t1_div == 2'h2) ? 2'h0 : t1_div + 2'h1;
      t1 <= (t1_div == 2'h2);
   end
   dual_stage_compare_timer i_dual_stage_compare_timer (.clk_i, .rst_b_i, .cfg_i(cfg),
      .port_alt_select_i(alt), .sleep_i(sleep), .osc_keep_running_i(osc),
      .ext_count_clock_in_i(ext), .timer1_tick_i(t1), .shift_clock_i(shift),
      .shift_halt_flag_i(halt), .ser_bit_valid_i(sv), .ser_bit_i(sb), .ser_bit_ready_o(ready),
      .timer_wave_out_o(wave), .prescale_clock_out_o(prescale_clock_out), .timer_irq_o(irq), .status_o(st));
   serial_unit_model i_serial_unit_model (.clk_i, .rst_b_i, .go_i(go), .ready_i(ready),
      .halt_o(halt), .shift_o(shift), .valid_o(sv), .bit_o(sb));
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t ns: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic stop_test();
      if (n_mismatch == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // Load with run low, then launch
   task automatic setup(input timer_cfg_s c);
      c.run_control = 1'b0;
      cfg <= c;
      cyc(2);
      c.run_control = 1'b1;
      cfg <= c;
      cyc(1);
   endtask
   initial begin
      #1ms;
      n_mismatch++;
      stop_test();
   end
   initial begin
      timer_cfg_s c;
      int n;
      logic [7:0] h;
      logic f;
      cyc(10);
      chk({wave, irq, prescale_clock_out, st}, '0);
      rst_b_i <= 1'b1;
      cyc(2);
      foreach (rows[i]) begin
         c = '{rows[i].src, 1'b0, 1'b0, rows[i].duty, rows[i].mode, OUT_TOGGLE, rows[i].lo,
            rows[i].hi, rows[i].mask};
         cfg <= c;
         cyc(2);
         chk({st.low_count, st.high_count}, '0);
         c.run_control = 1'b1;
         cfg <= c;
         k = 0;
         while (irq !== 1'b1 && k < 6000) begin cyc(1); k++; end
         n = 0;
         do begin cyc(1); n++; end while (irq !== 1'b1 && n < 6000);
         chk(n, rows[i].gap);
      end
      // Reset in mid-run clears stages and flip-flop
      rst_b_i <= 1'b0;
      cyc(2);
      chk({wave, irq, prescale_clock_out, st}, '0);
      rst_b_i <= 1'b1;
      cyc(2);
      setup('{CLK_SYSTEM, 1'b1, 1'b0, DUTY_BYPASS, MODE_SPLIT_RUN, OUT_TOGGLE, 4'hf, 8'hff, 5'h00});
      cyc(2);
      chk(wave, 1'b1);
      sleep <= 1'b1;
      setup('{CLK_SYSTEM, 1'b0, 1'b0, DUTY_BYPASS, MODE_SPLIT_RUN, OUT_TOGGLE, 4'hf, 8'hff, 5'h00});
      cyc(6);
      chk(st.high_count, 8'h00);
      alt <= 1'b1;
      repeat (6) begin ext <= 1'b1; cyc(3); ext <= 1'b0; cyc(3); end
      cyc(6);
      chk(st.high_count, 8'h06);
      alt <= 1'b0;
      osc <= 1'b1;
      cyc(2);
      h = st.high_count;
      cyc(4);
      chk(st.high_count, h + 8'h04);
      cfg.mode_sel <= MODE_SPLIT_STOP;
      cyc(2);
      h = st.high_count;
      chk(st.low_count, LOW_RESET);
      cyc(4);
      chk(st.high_count, h + 8'h04);
      sleep <= 1'b0;
      setup('{CLK_SHIFT, 1'b0, 1'b0, DUTY_BYPASS, MODE_SPLIT_RUN, OUT_SERIAL, 4'h4, 8'hff, 5'h00});
      go <= 1'b1;
      k = 0;
      while (ready !== 1'b0 && k < 40) begin cyc(1); k++; end
      chk(ready, 1'b0);
      while (st.modulator_on !== 1'b1 && k < 80) begin cyc(1); k++; end
      chk(st.modulator_on, 1'b1);
      n = 0;
      while (st.modulator_on === 1'b1 && k < 200) begin cyc(1); k++; n += shift; end
      chk(n, 5);
      chk(ready, 1'b1);
      go <= 1'b0;
      cyc(3);
      // Pulse width: a second match in one period is ignored
      setup('{CLK_SYSTEM, 1'b0, 1'b0, DUTY_BYPASS, MODE_SPLIT_RUN, OUT_PWM, 4'hf, 8'h03, 5'h08});
      f = st.output_toggle_ff;
      cyc(6);
      chk(st.output_toggle_ff, !f);
      cfg.high_compare <= 8'h0a;
      cyc(8);
      chk(st.output_toggle_ff, !f);
      chk(wave, !f);
      stop_test();
   end
endmodule
